// [rtl/cms_params.svh]
// constants for the converter mode select register bank
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CMS_ADDR_MAIN      4'h0
`define CMS_ADDR_COMMON    4'h1
`define CMS_ADDR_OFFS_1    4'h2
`define CMS_ADDR_RANGE_1   4'h3
`define CMS_ADDR_CAL_ADJ   4'h4
`define CMS_ADDR_OFFS_2    4'ha
`define CMS_ADDR_RANGE_2   4'hb
`define CMS_ADDR_PH_COARSE 4'hc
`define CMS_ADDR_PH_FILTER 4'hd
`define CMS_ADDR_SYNC      4'he
// one bit per implemented address; the rest read as zero
`define CMS_VALID_MASK     16'h7c1f

// ----------------------------------------------------------------
// main control, range and offset field positions
// ----------------------------------------------------------------
`define CMS_BIT_CAL        15
`define CMS_BIT_PHASE      14
`define CMS_BIT_SWING      13
`define CMS_BIT_TEST       12
`define CMS_BIT_PD_1       11
`define CMS_BIT_PD_2       10
`define CMS_BIT_DES        7
`define CMS_BIT_TWOS       4
`define CMS_RANGE_MSB      14
`define CMS_OFFS_SIGN      12
`define CMS_OFFS_MAG_MSB   11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CMS_RST_MAIN       16'h2000
`define CMS_RST_RANGE      16'h4000
`define CMS_RST_OTHER      16'h0000
`define CMS_RANGE_MID      15'h4000
`define CMS_RANGE_MIN      15'h0000
`define CMS_OFFS_ZERO      13'h0000

// ----------------------------------------------------------------
// serial frame counts, in serial clocks
// ----------------------------------------------------------------
`define CMS_ADDR_LAST      5'h06
`define CMS_CMD_BITS       5'h08
`define CMS_DATA_LAST      5'h17
`define CMS_FRAME_BITS     5'h18

`endif

// [rtl/cms_pkg.sv]
// types shared by the converter mode select block
package cms_pkg;

	// serial frame progress
	typedef enum logic [1:0] {
		CMS_IDLE,
		CMS_CMD,
		CMS_DATA,
		CMS_HOLD
	} cms_state_type;

	// the settings handed to the converter core
	typedef struct packed {
		logic        dual_edge;
		logic        data_clock_phase;
		logic        output_swing;
		logic        twos_complement;
		logic        test_pattern;
		logic        calibrate;
		logic        pd_first;
		logic        pd_second;
		logic [14:0] range_first;
		logic [14:0] range_second;
		logic [12:0] offset_first;
		logic [12:0] offset_second;
		logic        coupling;
		logic        out_common_mode;
		logic        demux;
		logic        cal_delay;
	} cms_cfg_type;

	// control pins as sampled
	typedef struct packed {
		logic des;
		logic data_clock_phase;
		logic test_pattern;
		logic calibrate;
		logic pd_first;
		logic pd_second;
		logic range;
		logic coupling;
		logic out_common_mode;
		logic demux;
		logic cal_delay;
	} cms_pins_type;

endpackage

// [rtl/cms_regbank.sv]
// sixteen-word configuration store with registered read port
`include "cms_params.svh"
module cms_regbank #(
	parameter int WORDS = 16,
	parameter int AW    = 4,
	parameter int DW    = 16
) (
	// clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                resetn_i,
	// return every word to its default
	input  wire logic                clear_i,
	// write port
	input  wire logic                wr_en_i,
	input  wire logic [AW-1:0]       wr_addr_i,
	input  wire logic [DW-1:0]       wr_data_i,
	// read port
	input  wire logic [AW-1:0]       rd_addr_i,
	output logic      [DW-1:0]       rd_data_o,
	// all words, for the settings mux
	output logic      [WORDS*DW-1:0] words_o
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	wire logic [WORDS-1:0] valid_w = `CMS_VALID_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < WORDS; gi++) begin : g_word
			localparam logic [AW-1:0] ADDR = AW'(gi);
			localparam logic [DW-1:0] RST =
				(ADDR == `CMS_ADDR_MAIN) ? `CMS_RST_MAIN :
				(ADDR == `CMS_ADDR_RANGE_1 ||
				 ADDR == `CMS_ADDR_RANGE_2) ? `CMS_RST_RANGE :
				`CMS_RST_OTHER;
			wire logic hit_w = wr_en_i && (wr_addr_i == ADDR);
			// unimplemented words never store, so they read zero
			always_ff @(posedge sys_clk_i) begin
				if (!resetn_i || clear_i || !valid_w[gi]) begin
					words_o[gi*DW +: DW] <= RST;
				end else if (hit_w) begin
					words_o[gi*DW +: DW] <= wr_data_i;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	wire logic [DW-1:0] rd_word_w = valid_w[rd_addr_i] ?
		words_o[rd_addr_i*DW +: DW] : '0;

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= rd_word_w;
		end
	end

endmodule

// [rtl/cms_top.sv]
// converter mode select: pin or serial register control of settings
`include "cms_params.svh"
module cms_top (
	// clock and reset
	input  wire logic            sys_clk_i,
	input  wire logic            resetn_i,
	// mode select, low for extended control
	input  wire logic            extended_mode_select_pin_i,
	// control pins
	input  cms_pkg::cms_pins_type pins_i,
	// serial register port
	input  wire logic            scs_n_i,
	input  wire logic            sclk_i,
	input  wire logic            sdi_i,
	output logic                 sdo_o,
	output logic                 sdo_oe_n_o,
	// settings toward the core
	output logic                 extended_control_mode_o,
	output cms_pkg::cms_cfg_type cfg_o
);
	import cms_pkg::*;

	// ----------------------------------------------------------------
	// mode and edge detection
	// ----------------------------------------------------------------
	logic          sclk_q;
	logic [4:0]    cnt_q;
	logic [4:0]    cnt_d;
	logic [14:0]   in_q;
	logic          rw_q;
	logic [3:0]    addr_q;
	logic [15:0]   out_q;
	logic          oe_n_q;
	cms_state_type state_q;
	cms_state_type state_d;
	logic [15:0]   rd_data_w;
	logic [255:0]  words_w;

	wire logic ecm_w  = !extended_mode_select_pin_i;
	wire logic rise_w = sclk_i && !sclk_q;
	wire logic fall_w = !sclk_i && sclk_q;
	// the port is dead outside extended mode; registers are in reset
	wire logic act_w  = !scs_n_i && ecm_w;

	// previous serial clock level for edge detection
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_i;
		end
	end

	// ----------------------------------------------------------------
	// frame sequencing
	// ----------------------------------------------------------------
	wire logic cnt_full_w = (cnt_q == `CMS_FRAME_BITS);
	wire logic wr_en_w    = act_w && rise_w && !rw_q &&
		(cnt_q == `CMS_DATA_LAST);
	wire logic [15:0] wr_data_w = {in_q, sdi_i};

	// count rising serial clocks; saturate so extra clocks do nothing
	always_comb begin
		cnt_d   = cnt_q;
		state_d = state_q;
		if (!act_w) begin
			cnt_d   = '0;
			state_d = CMS_IDLE;
		end else if (rise_w && !cnt_full_w) begin
			cnt_d = cnt_q + 5'h01;
			if (cnt_d == `CMS_FRAME_BITS) begin
				state_d = CMS_HOLD;
			end else if (cnt_d >= `CMS_CMD_BITS) begin
				state_d = CMS_DATA;
			end else begin
				state_d = CMS_CMD;
			end
		end else if (state_q == CMS_IDLE) begin
			state_d = CMS_CMD;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			cnt_q   <= '0;
			state_q <= CMS_IDLE;
		end else begin
			cnt_q   <= cnt_d;
			state_q <= state_d;
		end
	end

	// shift in command and data, capture flag and address
	// the three fixed bits are trusted, not checked
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			in_q   <= '0;
			rw_q   <= 1'b0;
			addr_q <= '0;
		end else if (act_w && rise_w && !cnt_full_w) begin
			in_q <= {in_q[13:0], sdi_i};
			if (cnt_q == 5'h00) begin
				rw_q <= sdi_i;
			end
			if (cnt_q == `CMS_ADDR_LAST) begin
				addr_q <= {in_q[2:0], sdi_i};
			end
		end
	end

	// ----------------------------------------------------------------
	// read data out, msb first from the eighth falling edge
	// ----------------------------------------------------------------
	wire logic load_w  = act_w && fall_w && rw_q &&
		(cnt_q == `CMS_CMD_BITS);
	// stop after the last bit so the final one holds until deselect
	wire logic shift_w = act_w && fall_w && rw_q && !oe_n_q &&
		(cnt_q > `CMS_CMD_BITS) && !cnt_full_w;

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			out_q  <= '0;
			oe_n_q <= 1'b1;
		end else if (!act_w) begin
			oe_n_q <= 1'b1;
		end else if (load_w) begin
			out_q  <= rd_data_w;
			oe_n_q <= 1'b0;
		end else if (shift_w) begin
			out_q <= {out_q[14:0], 1'b0};
		end
	end

	assign sdo_o      = out_q[15];
	assign sdo_oe_n_o = oe_n_q;

	// ----------------------------------------------------------------
	// register store
	// ----------------------------------------------------------------
	// leaving extended mode puts every word back to default
	cms_regbank #(
		.WORDS (16),
		.AW    (4),
		.DW    (16)
	) u_bank (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.clear_i   (!ecm_w),
		.wr_en_i   (wr_en_w),
		.wr_addr_i (addr_q),
		.wr_data_i (wr_data_w),
		.rd_addr_i (addr_q),
		.rd_data_o (rd_data_w),
		.words_o   (words_w)
	);

	wire logic [15:0] main_w   = words_w[0*16 +: 16];
	wire logic [15:0] offs1_w  = words_w[2*16 +: 16];
	wire logic [15:0] range1_w = words_w[3*16 +: 16];
	wire logic [15:0] offs2_w  = words_w[10*16 +: 16];
	wire logic [15:0] range2_w = words_w[11*16 +: 16];

	// ----------------------------------------------------------------
	// settings select
	// ----------------------------------------------------------------
	// pin mode offers only two ranges: mid and minimum
	wire logic [14:0] pin_range_w = pins_i.range ?
		`CMS_RANGE_MID : `CMS_RANGE_MIN;
	cms_cfg_type cfg_d;

	assign cfg_d.dual_edge = ecm_w ?
		main_w[`CMS_BIT_DES] : pins_i.des;
	assign cfg_d.data_clock_phase = ecm_w ?
		main_w[`CMS_BIT_PHASE] : pins_i.data_clock_phase;
	assign cfg_d.output_swing = ecm_w ?
		main_w[`CMS_BIT_SWING] : 1'b1;
	assign cfg_d.twos_complement = ecm_w &&
		main_w[`CMS_BIT_TWOS];
	assign cfg_d.test_pattern = ecm_w ?
		main_w[`CMS_BIT_TEST] : pins_i.test_pattern;
	// the pin stays live alongside the bit
	assign cfg_d.calibrate = pins_i.calibrate ||
		(ecm_w && main_w[`CMS_BIT_CAL]);
	assign cfg_d.pd_first = pins_i.pd_first ||
		(ecm_w && main_w[`CMS_BIT_PD_1]);
	assign cfg_d.pd_second = pins_i.pd_second ||
		(ecm_w && main_w[`CMS_BIT_PD_2]);
	// the core must be recalibrated by the host after a change
	assign cfg_d.range_first = ecm_w ?
		range1_w[`CMS_RANGE_MSB:0] : pin_range_w;
	assign cfg_d.range_second = ecm_w ?
		range2_w[`CMS_RANGE_MSB:0] : pin_range_w;
	assign cfg_d.offset_first = ecm_w ?
		offs1_w[`CMS_OFFS_SIGN:0] : `CMS_OFFS_ZERO;
	assign cfg_d.offset_second = ecm_w ?
		offs2_w[`CMS_OFFS_SIGN:0] : `CMS_OFFS_ZERO;
	assign cfg_d.coupling        = pins_i.coupling;
	assign cfg_d.out_common_mode = pins_i.out_common_mode;
	assign cfg_d.demux           = pins_i.demux;
	assign cfg_d.cal_delay       = pins_i.cal_delay;

	// one register stage so the core sees glitch-free settings
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			cfg_o                   <= '0;
			extended_control_mode_o <= 1'b0;
		end else begin
			cfg_o                   <= cfg_d;
			extended_control_mode_o <= ecm_w;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_mode_exit_reset: assert property (
		!ecm_w ##1 !ecm_w |-> main_w == `CMS_RST_MAIN &&
			range1_w == `CMS_RST_RANGE && offs1_w == `CMS_RST_OTHER &&
			range2_w == `CMS_RST_RANGE && offs2_w == `CMS_RST_OTHER)
		else $error("registers not at default outside extended mode");

	a_frame_write_hit: assert property (
		wr_en_w && addr_q == `CMS_ADDR_MAIN |=>
			main_w == $past(wr_data_w) ##1
			cfg_o.output_swing == $past(wr_data_w[13], 2))
		else $error("main word write not applied on 24th clock");

	a_short_frame_none: assert property (
		ecm_w && !wr_en_w |=> main_w == $past(main_w) &&
			range2_w == $past(range2_w))
		else $error("register word changed without a complete write");

	a_read_drive_start: assert property (
		$fell(oe_n_q) |-> $past(cnt_q) == `CMS_CMD_BITS &&
			$past(rw_q) && sdo_o == $past(rd_data_w[15]))
		else $error("read data not driven from eighth fall");

	a_read_release: assert property (
		scs_n_i |=> oe_n_q)
		else $error("serial out still driven after deselect");

	a_des_select: assert property (
		cfg_o.dual_edge == $past(ecm_w ? main_w[7] : pins_i.des))
		else $error("sampling mode source wrong");

	a_phase_select: assert property (
		cfg_o.data_clock_phase ==
			$past(ecm_w ? main_w[14] : pins_i.data_clock_phase))
		else $error("data clock phase source wrong");

	a_swing_pin_high: assert property (
		!ecm_w |=> cfg_o.output_swing)
		else $error("swing not high in pin mode");

	a_twos_pin_off: assert property (
		!ecm_w |=> !cfg_o.twos_complement)
		else $error("two's complement in pin mode");

	a_test_pin_ignore: assert property (
		ecm_w && !main_w[12] && pins_i.test_pattern |=>
			!cfg_o.test_pattern)
		else $error("test pattern pin acted in extended mode");

	a_cal_pin_live: assert property (
		pins_i.calibrate || (ecm_w && main_w[15]) |=>
			cfg_o.calibrate)
		else $error("calibration request lost");

	a_pd_first_or: assert property (
		cfg_o.pd_first ==
			$past(pins_i.pd_first || (ecm_w && main_w[11])))
		else $error("first channel power down wrong");

	a_pd_second_or: assert property (
		cfg_o.pd_second ==
			$past(pins_i.pd_second || (ecm_w && main_w[10])))
		else $error("second channel power down wrong");

	a_range_pin_pair: assert property (
		!ecm_w |=> cfg_o.range_first == ($past(pins_i.range) ?
			15'h4000 : 15'h0000) &&
			cfg_o.range_second == cfg_o.range_first)
		else $error("pin range not mid or minimum");

	a_range_ext_reg: assert property (
		ecm_w |=> cfg_o.range_second == $past(range2_w[14:0]))
		else $error("extended range not from register");

	a_offset_pin_zero: assert property (
		!ecm_w |=> cfg_o.offset_first == 13'h0000 &&
			cfg_o.offset_second == 13'h0000)
		else $error("offset applied in pin mode");

	a_pins_always: assert property (
		##1 cfg_o.demux == $past(pins_i.demux) &&
			cfg_o.cal_delay == $past(pins_i.cal_delay))
		else $error("pin-only setting not following its pin");

	a_mode_flag_copy: assert property (
		##1 extended_control_mode_o == $past(ecm_w))
		else $error("mode flag not following the mode pin");

	a_swing_ext_bit: assert property (
		ecm_w |=> cfg_o.output_swing == $past(main_w[13]))
		else $error("swing not from main word in extended mode");

	a_twos_ext_bit: assert property (
		ecm_w |=> cfg_o.twos_complement == $past(main_w[4]))
		else $error("number format not from main word");

	a_test_ext_bit: assert property (
		ecm_w |=> cfg_o.test_pattern == $past(main_w[12]))
		else $error("test pattern not from main word");

	a_cal_bit_pinmode: assert property (
		!ecm_w && !pins_i.calibrate |=> !cfg_o.calibrate)
		else $error("calibration raised without a request");

	a_range_first_reg: assert property (
		ecm_w |=> cfg_o.range_first == $past(range1_w[14:0]))
		else $error("first range not from register");

	a_offset_ext_reg: assert property (
		ecm_w |=> cfg_o.offset_first == $past(offs1_w[12:0]) &&
			cfg_o.offset_second == $past(offs2_w[12:0]))
		else $error("offset not from registers in extended mode");

	a_read_shift_next: assert property (
		shift_w |=> sdo_o == $past(out_q[14]))
		else $error("read data did not advance on a falling clock");

endmodule

// [tb/cms_host.sv]
// host model: drives the serial register port of the mode select block
module cms_host (
	// clock
	input  wire logic        sys_clk_i,
	// serial data back from the device
	input  wire logic        sdo_i,
	input  wire logic        sdo_oe_n_i,
	// serial port drive
	output logic             scs_n_o,
	output logic             sclk_o,
	output logic             sdi_o,
	// read result
	output logic             rd_done_o,
	output logic      [15:0] rd_word_o
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 3;
	logic sdo_last;
	wire  sdo_line;

	// a released line shows the inverse of its last value, never a held copy
	assign sdo_line = sdo_oe_n_i ? ~sdo_last : sdo_i;
	always @(posedge sys_clk_i) begin
		if (!sdo_oe_n_i) sdo_last <= sdo_i;
	end

	initial begin
		scs_n_o   = 1'b1;
		sclk_o    = 1'b0;
		sdi_o     = 1'b0;
		rd_done_o = 1'b0;
		rd_word_o = 16'h0000;
		sdo_last  = 1'b0;
	end

	// inputs change just after a rising edge, always by the same delay
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	// one access; n below 24 cuts the frame short, above 24 adds clocks
	task automatic frame(input logic rd, input logic [3:0] a,
			input logic [15:0] d, input int n);
		logic [23:0] f;
		f = {rd, 2'b10, a, 1'b0, d};
		cyc(1);
		scs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi_o = (i < 24) ? f[23-i] : 1'b0;
			cyc(HALF);
			sclk_o = 1'b1;
			if (i >= 8 && i < 24) rd_word_o = {rd_word_o[14:0], sdo_line};
			cyc(HALF);
			sclk_o = 1'b0;
		end
		// clock stands low outside frames
		cyc(HALF);
		scs_n_o = 1'b1;
		if (rd && n == 24) begin
			rd_done_o = 1'b1;
			cyc(1);
			rd_done_o = 1'b0;
		end
		cyc(2);
	endtask
endmodule

// [tb/cms_top_tb_top.sv]
// self-checking bench for the converter mode select block
module cms_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import cms_pkg::*;

	logic          sys_clk = 1'b0;
	logic          resetn  = 1'b0;
	logic          mode_pin = 1'b1;
	cms_pins_type  pins = '0;
	logic          scs_n, sclk, sdi, sdo, sdo_oe_n, extended_control_mode, rd_done;
	logic   [15:0] rd_word;
	cms_cfg_type   cfg;
	logic   [15:0] regs [16];
	logic   [15:0] exp_q [$];
	logic   [31:0] seed = 32'h7969c038;
	int            miscompares = 0;
	int            checks = 0;

	always #2.5 sys_clk = ~sys_clk;

	cms_top dut_u (
		.sys_clk_i(sys_clk), .resetn_i(resetn),
		.extended_mode_select_pin_i(mode_pin), .pins_i(pins),
		.scs_n_i(scs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
		.sdo_oe_n_o(sdo_oe_n), .extended_control_mode_o(extended_control_mode),
		.cfg_o(cfg));

	cms_host host_u (
		.sys_clk_i(sys_clk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n),
		.scs_n_o(scs_n), .sclk_o(sclk), .sdi_o(sdi),
		.rd_done_o(rd_done), .rd_word_o(rd_word));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// register defaults: swing high in main, mid range, all else zero
	function automatic void rst_regs();
		foreach (regs[i]) regs[i] = 16'h0000;
		regs[0]  = 16'h2000;
		regs[3]  = 16'h4000;
		regs[11] = 16'h4000;
	endfunction

	// settings expected from the pins and the shadow registers
	function automatic cms_cfg_type exp_cfg();
		cms_cfg_type e;
		logic [15:0] m;
		logic [14:0] pr;
		m  = regs[0];
		pr = pins.range ? 15'h4000 : 15'h0000;
		e.dual_edge        = mode_pin ? pins.des : m[7];
		e.data_clock_phase = mode_pin ? pins.data_clock_phase : m[14];
		e.output_swing     = mode_pin ? 1'b1 : m[13];
		e.twos_complement  = mode_pin ? 1'b0 : m[4];
		e.test_pattern     = mode_pin ? pins.test_pattern : m[12];
		e.calibrate        = pins.calibrate | (~mode_pin & m[15]);
		e.pd_first         = pins.pd_first | (~mode_pin & m[11]);
		e.pd_second        = pins.pd_second | (~mode_pin & m[10]);
		e.range_first      = mode_pin ? pr : regs[3][14:0];
		e.range_second     = mode_pin ? pr : regs[11][14:0];
		e.offset_first     = mode_pin ? 13'h0000 : regs[2][12:0];
		e.offset_second    = mode_pin ? 13'h0000 : regs[10][12:0];
		e.coupling         = pins.coupling;
		e.out_common_mode  = pins.out_common_mode;
		e.demux            = pins.demux;
		e.cal_delay        = pins.cal_delay;
		return e;
	endfunction

	task automatic settle();
		host_u.cyc(3);
		check(128'(cfg), 128'(exp_cfg()));
		check(128'(extended_control_mode), 128'(!mode_pin));
	endtask

	// writes to unmapped places are dropped in the shadow too
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		host_u.frame(1'b0, a, d, 24);
		if (16'h7c1f >> a & 16'h0001) regs[a] = d;
	endtask

	task automatic rd(input logic [3:0] a);
		exp_q.push_back((16'h7c1f >> a & 16'h0001) ? regs[a] : 16'h0000);
		host_u.frame(1'b1, a, 16'(rnd()), 24);
		check(128'(sdo_oe_n), 128'(1'b1));
	endtask

	// read results are taken off the queue as the host reports them
	always @(posedge sys_clk) begin
		if (rd_done) begin
			if (exp_q.size() == 0) check(128'(rd_word), 128'hx);
			else check(128'(rd_word), 128'(exp_q.pop_front()));
		end
	end

	// a full run needs well under 20k cycles; give up at 20k
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end

	initial begin
		logic [3:0] seq [8];
		seq = '{4'h0, 4'h3, 4'hb, 4'h2, 4'ha, 4'h0, 4'h3, 4'hb};
		rst_regs();
		host_u.cyc(3);
		resetn = 1'b1;
		// pin control
		for (int i = 0; i < 6; i++) begin
			pins = cms_pins_type'(11'(rnd()));
			settle();
		end
		// extended control: defaults, then random settings
		mode_pin = 1'b0;
		settle();
		rd(4'h0);
		rd(4'h3);
		rd(4'hb);
		rd(4'h5);
		for (int i = 0; i < 8; i++) begin
			wr(seq[i], 16'(rnd()));
			pins = cms_pins_type'(11'(rnd()));
			settle();
		end
		wr(4'h0, regs[0] | 16'h8000);
		settle();
		rd(4'h0);
		rd(4'ha);
		// a cut frame must not write
		host_u.frame(1'b0, 4'h0, ~regs[0], 16);
		rd(4'h0);
		// clocks past the 24th are ignored and the write still lands
		host_u.frame(1'b0, 4'hb, 16'h1357, 26);
		regs[11] = 16'h1357;
		settle();
		rd(4'hb);
		wr(4'h9, 16'hffff);
		rd(4'h9);
		// leaving extended mode clears the registers, port ignored
		mode_pin = 1'b1;
		host_u.frame(1'b0, 4'h3, 16'h1234, 24);
		rst_regs();
		settle();
		mode_pin = 1'b0;
		settle();
		rd(4'h0);
		rd(4'h3);
		host_u.cyc(5);
		check(128'(exp_q.size()), 128'h0);
		stop_test();
	end
endmodule
